// File: hw/color_tdm_pkg.sv
package color_tdm_pkg;

    // sample width of the panel stream and of the dac variant
    localparam int PANEL_COLOR_W = 8;
    localparam int VGA_COLOR_W = 10;

    // one pixel is this many samples of the fast clock
    localparam int SAMPLES_PER_PIXEL = 3;

    // depth of the buffer between capture and panel side
    localparam int WORD_FIFO_DEPTH = 16;

    // own clock period and the period of the fast clock in the bench, in ns
    localparam int REF_CLK_PERIOD_NS = 10;
    localparam int FAST_CLK_PERIOD_NS = 80;
    localparam int REF_PER_FAST = FAST_CLK_PERIOD_NS / REF_CLK_PERIOD_NS;

    // reset values
    localparam logic RST_LEVEL = 1'b0;
    localparam logic RST_PANEL_CLK = 1'b0;

    // which component was captured last
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_BLUE  = 4'h2,
        ST_GREEN = 4'h4,
        ST_RED   = 4'h8
    } phase_t;

endpackage

// File: hw/word_fifo.sv
`timescale 1ns/10ps
module word_fifo
    import color_tdm_pkg::*;
#(
    parameter int WIDTH = 3 * PANEL_COLOR_W,
    parameter int DEPTH = WORD_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire do_write;
    wire do_read;
    wire ptr_msb_differ;
    wire ptr_low_equal;

    assign ptr_msb_differ = wr_ptr_reg[AW] != rd_ptr_reg[AW];
    assign ptr_low_equal = wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0];
    // extra pointer bit tells full from empty
    assign in_ready = !(ptr_msb_differ && ptr_low_equal);
    assign out_valid = !(!ptr_msb_differ && ptr_low_equal);
    assign do_write = in_valid && in_ready;
    assign do_read = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (do_write) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_write) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_read) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

endmodule

// File: hw/color_tdm_demux.sv
`timescale 1ns/10ps
// Overview of operation
// - each pixel is three samples of fast clock
// - samples arrive blue, then green, then red
// - any sync edge marks the blue sample
// - three components form one parallel word
// - panel clock runs at one third rate
// - dac variant uses ten bit samples
// - dac variant sync edges mark blue too
// - input bit n feeds bit n of each
module color_tdm_demux
    import color_tdm_pkg::*;
#(
    parameter int COLOR_W = PANEL_COLOR_W,
    parameter int FIFO_DEPTH = WORD_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic fast_pixel_clock_in,
    input wire logic pixel_phase_sync,
    input wire logic [COLOR_W-1:0] muxed_color_in,
    input wire logic panel_enable,
    output logic panel_pixel_clock,
    output logic [COLOR_W-1:0] panel_red,
    output logic [COLOR_W-1:0] panel_green,
    output logic [COLOR_W-1:0] panel_blue,
    output logic capture_ready,
    output logic overrun,
    output logic sync_error,
    output logic locked
);
    localparam int WORD_W = SAMPLES_PER_PIXEL * COLOR_W;

    // pin synchronisers: first stage feeds only the second
    logic clk_s1_reg;
    logic clk_s2_reg;
    logic clk_s3_reg;
    logic sync_s1_reg;
    logic sync_s2_reg;
    logic [COLOR_W-1:0] data_s1_reg;
    logic [COLOR_W-1:0] data_s2_reg;

    logic sync_prev_reg;
    logic sync_seen_reg;
    phase_t state_reg;
    phase_t state_next;
    logic [COLOR_W-1:0] blue_reg;
    logic [COLOR_W-1:0] green_reg;
    logic panel_clk_reg;
    logic panel_clk_next;
    logic [COLOR_W-1:0] red_out_reg;
    logic [COLOR_W-1:0] green_out_reg;
    logic [COLOR_W-1:0] blue_out_reg;
    logic overrun_reg;
    logic sync_error_reg;

    wire cap;
    wire sync_edge;
    wire push;
    wire pop;
    wire enter_blue;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [WORD_W-1:0] fifo_in_data;
    wire [WORD_W-1:0] fifo_out_data;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clk_s1_reg <= RST_LEVEL;
            clk_s2_reg <= RST_LEVEL;
            clk_s3_reg <= RST_LEVEL;
            sync_s1_reg <= RST_LEVEL;
            sync_s2_reg <= RST_LEVEL;
        end else begin
            clk_s1_reg <= fast_pixel_clock_in;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            sync_s1_reg <= pixel_phase_sync;
            sync_s2_reg <= sync_s1_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_s1_reg <= '0;
            data_s2_reg <= '0;
        end else begin
            data_s1_reg <= muxed_color_in;
            data_s2_reg <= data_s1_reg;
        end
    end

    // sample on the falling fast edge: host launches on the rising one,
    // so mid-period sampling keeps clear of its data change
    assign cap = clk_s3_reg && !clk_s2_reg;
    // either polarity of sync change starts a pixel
    assign sync_edge = cap && sync_seen_reg && (sync_s2_reg != sync_prev_reg);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync_prev_reg <= RST_LEVEL;
            sync_seen_reg <= 1'b0;
        end else if (cap) begin
            sync_prev_reg <= sync_s2_reg;
            sync_seen_reg <= 1'b1;
        end
    end

    // phase walks blue, green, red; a sync edge forces blue at any point,
    // so a partly received pixel is dropped rather than mixed
    always_comb begin
        state_next = state_reg;
        if (sync_edge) begin
            state_next = ST_BLUE;
        end else if (cap) begin
            unique case (state_reg)
                ST_IDLE: state_next = ST_IDLE;
                ST_BLUE: state_next = ST_GREEN;
                ST_GREEN: state_next = ST_RED;
                ST_RED: state_next = ST_BLUE;
                default: state_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // one input lane per bit position feeds the same bit of each colour
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            blue_reg <= '0;
            green_reg <= '0;
        end else begin
            if (cap && state_next == ST_BLUE) begin
                blue_reg <= data_s2_reg;
            end
            if (cap && state_next == ST_GREEN) begin
                green_reg <= data_s2_reg;
            end
        end
    end

    // red is not stored apart; it joins the word in its own capture cycle
    assign push = cap && state_reg == ST_GREEN && !sync_edge;
    assign fifo_in_data = {data_s2_reg, green_reg, blue_reg};

    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_word_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // panel side: a word leaves at each blue capture, while the panel
    // clock is low; holding panel_enable low lets the buffer fill
    assign enter_blue = cap && state_next == ST_BLUE;
    assign pop = enter_blue && panel_enable && fifo_out_valid;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            red_out_reg <= '0;
            green_out_reg <= '0;
            blue_out_reg <= '0;
        end else if (pop) begin
            red_out_reg <= fifo_out_data[3*COLOR_W-1:2*COLOR_W];
            green_out_reg <= fifo_out_data[2*COLOR_W-1:COLOR_W];
            blue_out_reg <= fifo_out_data[COLOR_W-1:0];
        end
    end

    // low for the blue third, high for green and red: one period per pixel
    always_comb begin
        panel_clk_next = panel_clk_reg;
        if (cap) begin
            panel_clk_next = (state_next == ST_GREEN) || (state_next == ST_RED);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            panel_clk_reg <= RST_PANEL_CLK;
        end else begin
            panel_clk_reg <= panel_clk_next;
        end
    end

    // sticky flags; only reset clears them, so no clear race exists
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            overrun_reg <= 1'b0;
            sync_error_reg <= 1'b0;
        end else begin
            if (push && !fifo_in_ready) begin
                overrun_reg <= 1'b1;
            end
            if (sync_edge && state_reg != ST_RED && state_reg != ST_IDLE) begin
                sync_error_reg <= 1'b1;
            end
        end
    end

    assign panel_pixel_clock = panel_clk_reg;
    assign panel_red = red_out_reg;
    assign panel_green = green_out_reg;
    assign panel_blue = blue_out_reg;
    assign capture_ready = fifo_in_ready;
    assign overrun = overrun_reg;
    assign sync_error = sync_error_reg;
    assign locked = state_reg != ST_IDLE;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_blue_taken;
        cap && sync_edge;
    endsequence

    sequence s_green_taken;
        cap && !sync_edge && state_reg == ST_BLUE;
    endsequence

    sequence s_red_taken;
        cap && !sync_edge && state_reg == ST_GREEN;
    endsequence

    a_sync_marks_blue: assert property (
        s_blue_taken |=> state_reg == ST_BLUE && blue_reg == $past(data_s2_reg)
    ) else $error("sync edge did not start a pixel on blue");

    a_green_follows: assert property (
        s_green_taken |=> state_reg == ST_GREEN && green_reg == $past(data_s2_reg)
    ) else $error("green sample not taken after blue");

    a_word_pushed: assert property (
        s_red_taken |-> push && fifo_in_data[COLOR_W-1:0] == blue_reg
            && fifo_in_data[3*COLOR_W-1:2*COLOR_W] == data_s2_reg
    ) else $error("red sample did not complete the word");

    a_no_push_idle: assert property (
        state_reg == ST_IDLE |-> !push && !panel_clk_reg
    ) else $error("word produced before first sync edge");

    a_capture_spacing: assert property (
        cap |=> !cap
    ) else $error("two captures in adjacent cycles");

    a_pclk_rise: assert property (
        $rose(panel_clk_reg) |-> state_reg == ST_GREEN && $past(cap)
    ) else $error("panel clock rose outside green capture");

    a_pclk_fall: assert property (
        $fell(panel_clk_reg) |-> state_reg == ST_BLUE && $past(cap)
    ) else $error("panel clock fell outside blue capture");

    a_out_together: assert property (
        (!$stable(red_out_reg) || !$stable(green_out_reg) || !$stable(blue_out_reg))
            |-> $past(pop) && !panel_clk_reg
    ) else $error("output word changed outside a pop");

    a_pixel_complete: assert property (
        s_red_taken ##1 (!cap)[*2] |-> panel_clk_reg && state_reg == ST_RED
    ) else $error("panel clock or phase wrong during red third");

    a_overrun_flag: assert property (
        push && !fifo_in_ready |=> overrun_reg
    ) else $error("lost word not flagged");

endmodule

// File: bench/host_stream_model.sv
`timescale 1ns/10ps
module host_stream_model
    import color_tdm_pkg::*;
#(
    parameter int W = PANEL_COLOR_W
) (
    input wire logic ref_clk,
    output logic fast_clk,
    output logic sync,
    output logic [W-1:0] data
);
    // panel line in pixel periods; the bench pixel rate is slower than the
    // panel's, but porch and active proportions are kept
    localparam int ACTIVE_PIXELS = 800;
    localparam int LINE_PIXELS = 1056;
    localparam int BACK_PORCH = 216;
    initial begin
        fast_clk = 1'b0;
        sync = 1'b0;
        data = '0;
    end
    // launch on the rising edge so the value is settled by the falling one
    task automatic send_sample(input logic [W-1:0] value, input bit mark);
        @(negedge ref_clk);
        fast_clk = 1'b1;
        data = value;
        if (mark) begin
            sync = ~sync;
        end
        repeat (REF_PER_FAST / 2) @(negedge ref_clk);
        fast_clk = 1'b0;
        repeat (REF_PER_FAST / 2 - 1) @(negedge ref_clk);
    endtask
    task automatic send_pixel(input logic [W-1:0] r, g, b, input bit mark);
        send_sample(b, mark);
        send_sample(g, 1'b0);
        send_sample(r, 1'b0);
    endtask
    // blank back porch, active pixels, blank front porch to the line end;
    // sync changes once, on the first blue of the line
    task automatic send_line();
        for (int p = 0; p < LINE_PIXELS; p++) begin
            if (p >= BACK_PORCH && p < BACK_PORCH + ACTIVE_PIXELS) begin
                send_pixel(W'(p), W'(p + 1), W'(p + 2), p == 0);
            end else begin
                send_pixel('0, '0, '0, p == 0);
            end
        end
    endtask
    // clock stands still outside frames, stale data must not look valid
    task automatic release_bus();
        @(negedge ref_clk);
        data = ~data;
    endtask
endmodule

// File: bench/test_color_tdm_demux.sv
`timescale 1ns/10ps
module test_color_tdm_demux
    import color_tdm_pkg::*;
;
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic mark;
        logic [23:0] exp;
    } row_t;
    localparam row_t ROWS [6] = '{
        '{8'h81, 8'h42, 8'h24, 1'b1, 24'h000000}, '{8'h18, 8'h7e, 8'he7, 1'b0, 24'h814224},
        '{8'hff, 8'h00, 8'h5a, 1'b1, 24'h187ee7}, '{8'h00, 8'hff, 8'ha5, 1'b1, 24'hff005a},
        '{8'hc3, 8'h3c, 8'h99, 1'b0, 24'h00ffa5}, '{8'h01, 8'h80, 8'hfe, 1'b1, 24'hc33c99}};
    logic ref_clk, nrst, panel_enable, fclk, sync, fclk10, sync10;
    logic [7:0] data, red, green, blue;
    logic [9:0] data10, red10, green10, blue10;
    logic pclk, ready, overrun, sync_error, locked, pclk_d;
    int err_count, cmp_count, cyc, last_rise, period;
    host_stream_model host (.ref_clk(ref_clk), .fast_clk(fclk), .sync(sync), .data(data));
    host_stream_model #(.W(VGA_COLOR_W)) host10 (
        .ref_clk(ref_clk), .fast_clk(fclk10), .sync(sync10), .data(data10));
    color_tdm_demux uut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .fast_pixel_clock_in(fclk),
        .pixel_phase_sync(sync),
        .muxed_color_in(data),
        .panel_enable(panel_enable),
        .panel_pixel_clock(pclk),
        .panel_red(red),
        .panel_green(green),
        .panel_blue(blue),
        .capture_ready(ready),
        .overrun(overrun),
        .sync_error(sync_error),
        .locked(locked)
    );
    color_tdm_demux #(.COLOR_W(VGA_COLOR_W)) uut_dac (
        .ref_clk(ref_clk), .nrst(nrst), .fast_pixel_clock_in(fclk10),
        .pixel_phase_sync(sync10), .muxed_color_in(data10), .panel_enable(1'b1),
        .panel_pixel_clock(), .panel_red(red10), .panel_green(green10),
        .panel_blue(blue10), .capture_ready(), .overrun(), .sync_error(), .locked());
    initial begin
        ref_clk = 1'b0;
        forever #(REF_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // panel clock period in own cycles, measured between rising edges
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        pclk_d <= pclk;
        if (pclk && !pclk_d) begin
            period <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (cyc == 40000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        nrst = 1'b0;
        panel_enable = 1'b1;
        repeat (6) @(negedge ref_clk);
        check({pclk, ready, overrun, sync_error, locked}, 5'b01000);
        check({red, green, blue}, 24'h0);
        nrst = 1'b1;
        // first capture only learns the sync level
        host.send_sample(8'h3c, 1'b0);
        check(locked, 1'b0);
        $display("test reset done");
        // one whole line; its blank last pixel is popped by table row 0
        host.send_line();
        check({locked, overrun, sync_error}, 3'b100);
        check({red, green, blue}, 24'h0);
        $display("test line done");
        // output word lags one pixel: popped at the next blue capture
        for (int i = 0; i < 6; i++) begin
            host.send_pixel(ROWS[i].r, ROWS[i].g, ROWS[i].b, ROWS[i].mark);
            check({red, green, blue}, ROWS[i].exp);
        end
        check(locked, 1'b1);
        check(period, 3 * REF_PER_FAST);
        $display("test table done");
        // sync edge on a green sample drops that partial pixel
        host.send_sample(8'h11, 1'b1);
        host.send_sample(8'h22, 1'b1);
        host.send_pixel(8'h5e, 8'h6d, 8'h7c, 1'b1);
        check(sync_error, 1'b1);
        check({red, green, blue}, 24'h0180fe);
        host.send_pixel(8'h9a, 8'hab, 8'hbc, 1'b1);
        check({red, green, blue}, 24'h5e6d7c);
        $display("test sync error done");
        // stall the panel side until the buffer refuses
        @(negedge ref_clk);
        panel_enable = 1'b0;
        for (int k = 0; k < 16; k++) begin
            if (k == 15) begin
                check({ready, overrun}, 2'b00);
            end
            host.send_pixel(8'(k), 8'(8'h10 + k), 8'(8'h20 + k), 1'b0);
        end
        check({ready, overrun}, 2'b01);
        check({red, green, blue}, 24'h5e6d7c);
        @(negedge ref_clk);
        panel_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            host.send_sample(8'h44, 1'b0);
            host.send_sample(8'h55, 1'b0);
            check(ready, 1'b1);
            host.send_sample(8'h66, 1'b0);
            if (k == 0) begin
                check({red, green, blue}, 24'h9aabbc);
            end else begin
                check({red, green, blue}, {8'(k - 1), 8'(8'h0f + k), 8'(8'h1f + k)});
            end
        end
        host.release_bus();
        $display("test buffer done");
        host10.send_sample(10'h155, 1'b0);
        host10.send_pixel(10'h3ff, 10'h201, 10'h0aa, 1'b1);
        host10.send_pixel(10'h111, 10'h222, 10'h333, 1'b1);
        check({red10, green10, blue10}, {10'h3ff, 10'h201, 10'h0aa});
        host10.release_bus();
        $display("test dac variant done");
        // mid-run reset clears flags and words, then relearns the sync level
        @(negedge ref_clk);
        nrst = 1'b0;
        #1;
        check({pclk, ready, overrun, sync_error, locked}, 5'b01000);
        check({red, green, blue}, 24'h0);
        @(negedge ref_clk);
        nrst = 1'b1;
        host.send_sample(8'h3c, 1'b0);
        check(locked, 1'b0);
        host.send_pixel(8'h12, 8'h34, 8'h56, 1'b1);
        host.send_pixel(8'h65, 8'h43, 8'h21, 1'b0);
        check({red, green, blue, overrun, sync_error}, {24'h123456, 2'b00});
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
